/* File: hbds_pkg.sv */
// hbds_pkg: constants and types shared by the host bus decode and strap block
// assumes a single 125 MHz clock domain and synchronous active-high reset
package hbds_pkg;
  localparam int HBDS_ADDR_W = 16;
  localparam int HBDS_DEC_HI = 15; // decoded address bits 15..4
  localparam int HBDS_DEC_LO = 4;
  localparam int HBDS_BASE_BYTE_LO = 8; // upper byte of base address register
  localparam logic [15:0] HBDS_BASE_RST = 16'h0300;
  localparam int HBDS_CLK_MHZ = 125;
  localparam int HBDS_ACC_NS = 40; // internal access service time
  localparam int HBDS_ACC_CYC = (HBDS_ACC_NS * HBDS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] HBDS_ACC_CYC_W = 4'(HBDS_ACC_CYC);
  typedef enum logic {HBDS_MODE_SYNC, HBDS_MODE_ASYNC} hbds_mode_t;
  typedef enum logic [1:0] {HBDS_IDLE, HBDS_WAIT, HBDS_DONE} hbds_state_t;
endpackage

/* File: hbds_strap.sv */
// hbds_strap: captures the mode and eeprom straps once after reset release
// assumes strap pins are stable and synchronous to clk
`timescale 1ns/1ps
module hbds_strap
  import hbds_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic bus_mode_strap,
  input wire logic eeprom_enable_strap,
  output hbds_mode_t mode,
  output logic eeprom_en
);
  logic taken_r;
  // first enabled cycle after reset latches the straps and locks them
  always_ff @(posedge clk) begin
    if (srst) begin
      taken_r <= 1'b0;
      mode <= HBDS_MODE_SYNC;
      eeprom_en <= 1'b0;
    end else if (ce && !taken_r) begin
      taken_r <= 1'b1;
      mode <= bus_mode_strap ? HBDS_MODE_ASYNC : HBDS_MODE_SYNC;
      eeprom_en <= eeprom_enable_strap;
    end
  end
endmodule // hbds_strap

/* File: hbds_top.sv */
// hbds_top: local device decode, ready generation and strap configuration
// assumes host pins are synchronous to clk; the host keeps its own bus rules
`timescale 1ns/1ps
module hbds_top
  import hbds_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [15:0] address,
  input wire logic [15:0] base_address,
  input wire logic address_qualifier_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic cycle_qualifier_n,
  input wire logic sync_write_read_select,
  input wire logic ready_return_n,
  input wire logic bus_mode_strap,
  input wire logic eeprom_enable_strap,
  output logic local_device_select_n,
  output logic async_access_ready,
  output logic sync_ready_n,
  output logic eeprom_chip_select_en,
  output logic sync_mode,
  output logic burst_read,
  output logic access_write
);
  // strap view handed up from the capture module
  hbds_mode_t mode;
  logic eeprom_en;
  logic async_mode;

  // access service state and its next values
  hbds_state_t state_r;
  hbds_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // decode and access qualifiers
  logic [HBDS_DEC_HI-HBDS_DEC_LO:0] bit_match;
  logic addr_match;
  logic hit;
  logic strobe_low;
  logic start;
  logic take;
  logic last_wait;
  logic host_done;

  // next values of the registered outputs
  logic async_ready_nxt;
  logic sync_ready_nxt;
  logic burst_read_nxt;
  logic access_write_nxt;

  hbds_strap u_strap (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .bus_mode_strap(bus_mode_strap),
    .eeprom_enable_strap(eeprom_enable_strap),
    .mode(mode),
    .eeprom_en(eeprom_en)
  );

  // one compare per decoded address bit against the base register
  for (genvar b = 0; b <= HBDS_DEC_HI - HBDS_DEC_LO; b++) begin : g_match
    assign bit_match[b] = (address[HBDS_DEC_LO + b] == base_address[HBDS_DEC_LO + b]);
  end

  // no flop in the select path, so it follows the pins at once;
  // the price is that glitches on the address lines reach the select pin
  assign addr_match = &bit_match;
  assign hit = !address_qualifier_n && addr_match;
  assign local_device_select_n = !hit;

  // mode view used by every decision below
  assign async_mode = (mode == HBDS_MODE_ASYNC);

  // access start: strobes in async mode, cycle qualifier in sync mode
  assign strobe_low = !read_strobe_n || !write_strobe_n;
  assign start = hit && (async_mode ? strobe_low : !cycle_qualifier_n);

  // only an idle machine takes a request; starts while busy are ignored
  assign take = (state_r == HBDS_IDLE) && start;

  // the wait count has reached its end in this cycle
  assign last_wait = (state_r == HBDS_WAIT) && (cnt_r <= 4'h1);

  // async ends when both strobes are back high; sync writes end at once,
  // sync reads stay until the host returns ready
  assign host_done = async_mode ? !strobe_low : (sync_write_read_select || !ready_return_n);

  // next state of the access service machine
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      HBDS_IDLE: begin
        if (start) begin
          state_nxt = HBDS_WAIT;
          cnt_nxt = HBDS_ACC_CYC_W;
        end
      end
      HBDS_WAIT: begin
        if (cnt_r <= 4'h1) begin
          state_nxt = HBDS_DONE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      HBDS_DONE: begin
        // holding here keeps a long strobe from starting a second access
        if (host_done) begin
          state_nxt = HBDS_IDLE;
        end
      end
      default: begin
        state_nxt = HBDS_IDLE;
      end
    endcase
  end

  // state register; ce low freezes the machine where it stands
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= HBDS_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // wait counter, loaded on take and counted down while waiting
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 4'h0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  // async ready drops with the taken strobe and rises on the last wait cycle,
  // so the host sees exactly the service time as stretch
  assign async_ready_nxt = !(async_mode && (take || ((state_r == HBDS_WAIT) && !last_wait)));

  // sync ready is a single low cycle at the end of the wait
  assign sync_ready_nxt = !(!async_mode && last_wait);

  // async ready register, high out of reset so the bus is never held
  always_ff @(posedge clk) begin
    if (srst) begin
      async_access_ready <= 1'b1;
    end else if (ce) begin
      async_access_ready <= async_ready_nxt;
    end
  end

  // sync ready register, idle high
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_ready_n <= 1'b1;
    end else if (ce) begin
      sync_ready_n <= sync_ready_nxt;
    end
  end

  // burst qualifier level at access start marks a read burst when high
  assign burst_read_nxt = take ? cycle_qualifier_n : burst_read;

  // write flag: select pin in sync mode, write strobe in async mode
  assign access_write_nxt = take ? (async_mode ? !write_strobe_n : sync_write_read_select) : access_write;

  // burst direction register
  always_ff @(posedge clk) begin
    if (srst) begin
      burst_read <= 1'b0;
    end else if (ce) begin
      burst_read <= burst_read_nxt;
    end
  end

  // write direction register
  always_ff @(posedge clk) begin
    if (srst) begin
      access_write <= 1'b0;
    end else if (ce) begin
      access_write <= access_write_nxt;
    end
  end

  // strap views; both are fixed between resets by the capture module
  assign sync_mode = !async_mode;
  assign eeprom_chip_select_en = eeprom_en;
endmodule // hbds_top

/* File: hbds_top_props.sv */
// hbds_top_props: port assertions for hbds_top
// assumes ce stays high, so the straps load at the first edge after reset
`timescale 1ns/1ps
module hbds_top_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] address,
  input wire logic [15:0] base_address,
  input wire logic address_qualifier_n,
  input wire logic bus_mode_strap,
  input wire logic eeprom_enable_strap,
  input wire logic local_device_select_n,
  input wire logic async_access_ready,
  input wire logic sync_ready_n,
  input wire logic eeprom_chip_select_en,
  input wire logic sync_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // five wait cycles, then ready comes back
  sequence s_wait; !async_access_ready [*5] ##1 async_access_ready; endsequence
  property p_dec; local_device_select_n == (address_qualifier_n || address[15:4] != base_address[15:4]); endproperty
  a_dec: assert property (p_dec) else $error("decode");
  property p_async_access_ready; $fell(async_access_ready) |-> s_wait; endproperty
  a_async_access_ready: assert property (p_async_access_ready) else $error("stretch");
  property p_load; $fell(srst) |=> sync_mode == !$past(bus_mode_strap) && eeprom_chip_select_en == $past(eeprom_enable_strap);
  endproperty
  a_load: assert property (p_load) else $error("strap load");
  property p_hold; !$fell(srst) |=> $stable({sync_mode, eeprom_chip_select_en}); endproperty
  a_hold: assert property (p_hold) else $error("strap hold");
  property p_srdy; $fell(sync_ready_n) |=> sync_ready_n; endproperty
  a_srdy: assert property (p_srdy) else $error("sync ready pulse");
  property p_quiet; sync_mode |-> async_access_ready; endproperty
  a_quiet: assert property (p_quiet) else $error("async ready in sync mode");
endmodule // hbds_top_props
bind hbds_top hbds_top_props i_hbds_top_props (.*);

/* File: hbds_host.sv */
// hbds_host: host model, one asynchronous read for each rise of go
`timescale 1ns/1ps
module hbds_host (
  input wire logic clk,
  input wire logic go,
  output logic read_strobe_n
);
  initial read_strobe_n = 1;
  // strobe held past the longest stretch, since no ready wait is modelled
  always @(posedge go) begin
    @(posedge clk);
    #1 read_strobe_n = 0;
    repeat (9) @(posedge clk);
    #1 read_strobe_n = 1;
  end
endmodule // hbds_host

/* File: hbds_top_test.sv */
// hbds_top_test: strap, decode and async read checks
`timescale 1ns/1ps
module hbds_top_test;
  import hbds_pkg::*;
  logic clk = 0, srst = 1, go = 0, address_qualifier_n = 1, bus_mode_strap, eeprom_enable_strap, read_strobe_n;
  logic local_device_select_n, async_access_ready, eeprom_chip_select_en, sync_mode;
  logic write_strobe_n = 1, cycle_qualifier_n = 1, sync_write_read_select = 0, ready_return_n = 1;
  logic sync_ready_n, burst_read, access_write;
  logic [15:0] address = 16'h0000, base_address = HBDS_BASE_RST;
  logic [31:0] x = 32'h0000002F;
  int n_mismatch = 0, num_checks = 0, n = 0;
  always #4 clk = ~clk;
  hbds_host i_hbds_host (.*);
  hbds_top i_hbds_top (.*, .ce(1'b1));
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(string s, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #20000 n_mismatch++;
    close_out();
  end
  initial begin
    // every strap pair, then flipped straps must not leak in
    for (int i = 0; i < 4; i++) begin
      {eeprom_enable_strap, bus_mode_strap} = i[1:0];
      srst = 1;
      repeat (10) @(posedge clk);
      #1 srst = 0;
      repeat (2) @(posedge clk);
      #1 {eeprom_enable_strap, bus_mode_strap} = ~i[1:0];
      repeat (2) @(posedge clk);
      #1 check("sync_mode", !i[0], sync_mode);
      check("eeprom", i[1], eeprom_chip_select_en);
      $display("strap test %0d done", i);
    end
    // random decode, half forced to hit in the compared bits
    repeat (100) begin
      @(posedge clk);
      #1 {address, base_address} = rnd();
      address_qualifier_n = x[7];
      if (x[9]) base_address[15:4] = address[15:4];
      #1 check("select", address_qualifier_n || address[15:4] != base_address[15:4], local_device_select_n);
    end
    // async read at a hit, counting stretched cycles
    @(posedge clk);
    #1 address = base_address;
    address_qualifier_n = 0;
    go = 1;
    repeat (12) @(posedge clk) n += !async_access_ready;
    check("stretch", 1, n == HBDS_ACC_CYC);
    check("burst_read", 1, burst_read);
    check("async_write", 0, access_write);
    $display("decode and read tests done");
    // sync read: one ready pulse, then held until ready return
    #1 go = 0;
    {eeprom_enable_strap, bus_mode_strap} = 2'b00;
    srst = 1;
    repeat (10) @(posedge clk);
    #1 srst = 0;
    repeat (2) @(posedge clk);
    #1 cycle_qualifier_n = 0;
    n = 0;
    repeat (12) @(posedge clk) n += !sync_ready_n;
    check("sync_ready", 1, n == 1);
    check("sync_write", 0, access_write);
    #1 ready_return_n = 0;
    cycle_qualifier_n = 1;
    repeat (2) @(posedge clk);
    $display("sync read test done");
    close_out();
  end
endmodule // hbds_top_test
